// File: logic/pmbcf_pkg.sv
// Purpose: Shared constants for the converter configuration command bank
// Assumes: 250 MHz controller clock, 16-bit command data words
// Notes:   Command codes double as register offsets
`default_nettype none
package pmbcf_pkg;
   // Command codes
   localparam logic [7:0] CMD_SCALE = 8'h29;
   localparam logic [7:0] CMD_FREQ = 8'h33;
   localparam logic [7:0] CMD_INPUT_ON = 8'h35;
   localparam logic [7:0] CMD_INPUT_OFF = 8'h36;
   localparam logic [7:0] CMD_SYNC = 8'h37;
   localparam logic [7:0] CMD_OV_LIMIT = 8'h40;
   localparam logic [7:0] CMD_STATUS = 8'h7E;
   // Non-volatile defaults
   localparam logic [15:0] RST_SCALE = 16'hE808;
   localparam logic [15:0] RST_FREQ = 16'h0258;
   localparam logic [15:0] RST_INPUT_ON = 16'hF814;
   localparam logic [15:0] RST_INPUT_OFF = 16'hF812;
   localparam logic [15:0] RST_SYNC = 16'h0100;
   localparam logic [15:0] RST_OV_LIMIT = 16'h0161;
   // Scale factor codes
   localparam logic [15:0] SCALE_1_0 = 16'hE808;
   localparam logic [15:0] SCALE_0_5 = 16'hE804;
   localparam logic [15:0] SCALE_0_25 = 16'hE802;
   localparam logic [15:0] SCALE_0_125 = 16'hE801;
   // Linear-11 field layout and fixed exponents
   localparam int L11_EXP_MSB = 15;
   localparam int L11_EXP_LSB = 11;
   localparam int L11_MAN_MSB = 10;
   localparam int OFM_EXP_MSB = 4;
   localparam logic [4:0] EXP_SCALE = 5'h1D;
   localparam logic [4:0] EXP_FREQ = 5'h00;
   localparam logic [4:0] EXP_VIN = 5'h1F;
   // Value limits
   localparam logic [10:0] FREQ_MIN_KHZ = 11'h12C;
   localparam logic [10:0] FREQ_MAX_KHZ = 11'h5DC;
   localparam logic [10:0] FREQ_STEP_KHZ = 11'h032;
   localparam logic [10:0] VIN_MAN_MIN = 11'h002;
   localparam logic [10:0] VIN_MAN_MAX = 11'h0A0;
   localparam logic [31:0] VIN_MV_PER_LSB = 32'h000001F4;
   localparam logic [31:0] OV_MIN_MV = 32'h0000012C;
   localparam logic [31:0] OV_MAX_MV = 32'h000036B0;
   // Setpoint thresholds for automatic scale choice
   localparam logic [15:0] AUTO_LIM_1_0_MV = 16'h0708;
   localparam logic [15:0] AUTO_LIM_0_5_MV = 16'h0CE4;
   localparam logic [15:0] AUTO_LIM_0_25_MV = 16'h1388;
   // Synchronisation mode codes
   localparam logic [15:0] SYNC_STANDALONE = 16'h0000;
   localparam logic [15:0] SYNC_MASTER = 16'h0100;
   localparam logic [15:0] SYNC_SLAVE_0 = 16'h0120;
   localparam logic [15:0] SYNC_SLAVE_180 = 16'h0121;
   // Clock rate and phase accumulator step per kHz
   localparam longint CLK_KHZ = 250000;
   localparam logic [31:0] PHASE_INC_PER_KHZ = 32'(64'h100000000 / CLK_KHZ);
   localparam logic [31:0] PHASE_HALF = 32'h80000000;
   // Status word bit positions
   localparam int ST_CMD_ERR = 0;
   localparam int ST_CONV_ON = 1;
   localparam int ST_OV_FAULT = 2;
   localparam int ST_FREQ_CMD = 3;
   // Sync modes, Gray coded along standalone-master-slave-slave180
   typedef enum logic [1:0] {
      PMBCF_STANDALONE = 2'h0,
      PMBCF_MASTER = 2'h1,
      PMBCF_SLAVE_0 = 2'h3,
      PMBCF_SLAVE_180 = 2'h2
   } pmbcf_sync_e;
endpackage
`default_nettype wire

// File: logic/pmbcf_phase_gen.sv
// Purpose: Switching clock generator with phase lock to an external edge
// Assumes: ext_edge_i is a one-cycle pulse already synchronised
// Notes:   Accumulator MSB gives a 50% duty switching clock
`default_nettype none
module pmbcf_phase_gen
   import pmbcf_pkg::*;
#(
   parameter int ACC_W = 32
) (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic [10:0] freq_khz_i,
   input wire logic slave_i,
   input wire logic anti_phase_i,
   input wire logic ext_edge_i,
   output logic sw_clk_o
);
   logic [ACC_W-1:0] acc;
   logic [ACC_W-1:0] step;

   // Step per cycle; frequency resolution is coarse but duty stays exact
   assign step = ACC_W'(freq_khz_i * PHASE_INC_PER_KHZ);

   // Slave re-aligns phase on each external edge, 0 or half a period
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         acc <= '0;
      end else if (ce_i) begin
         if (slave_i && ext_edge_i) begin
            acc <= anti_phase_i ? ACC_W'(PHASE_HALF >> (32 - ACC_W)) : '0;
         end else begin
            acc <= acc + step;
         end
      end
   end

   assign sw_clk_o = acc[ACC_W-1];
endmodule
`default_nettype wire

// File: logic/pmbcf_bank.sv
// Purpose: Configuration command bank for a buck converter controller
// Assumes: Bus transaction layer delivers decoded command code and word
// Notes:   Rejected writes keep old contents and latch a command error
`default_nettype none
module pmbcf_bank
   import pmbcf_pkg::*;
(
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic wr_en_i,
   input wire logic [15:0] wr_data_i,
   input wire logic rd_en_i,
   input wire logic [7:0] output_format_mode_i,
   input wire logic setpoint_resistor_pin_i,
   input wire logic [15:0] setpoint_mv_i,
   input wire logic [10:0] rt_freq_khz_i,
   input wire logic [31:0] vin_mv_i,
   input wire logic [31:0] vout_mv_i,
   input wire logic vdd_ok_i,
   input wire logic freq_resistor_sync_pin_i,
   output logic freq_resistor_sync_pin_o,
   output logic freq_resistor_sync_pin_oe_o,
   output logic [15:0] rd_data_o,
   output logic rd_valid_o,
   output logic cmd_err_o,
   output logic conv_en_o,
   output logic ov_fault_o,
   output logic sw_clk_o,
   output logic [15:0] output_scale_factor_o
);
   logic [15:0] output_scale_factor;
   logic [15:0] switching_freq_setting;
   logic [15:0] input_turn_on_threshold;
   logic [15:0] input_turn_off_threshold;
   logic [15:0] phase_sync_config;
   logic [15:0] output_overvoltage_limit;
   logic freq_cmd_seen;
   logic wr_ok;
   logic wr_bad;
   logic rd_bad;
   logic [15:0] auto_scale;
   logic [10:0] freq_eff;
   logic [31:0] on_mv;
   logic [31:0] off_mv;
   logic [31:0] ov_mv;
   logic [1:0] sync_ff;
   logic sync_prev;
   logic [1:0] vdd_ff;
   logic [1:0] pin_ff;
   logic ext_edge;
   pmbcf_sync_e mode;

   // Known command test, used by the read path only
   function automatic logic is_known(input logic [7:0] c);
      is_known = (c == CMD_SCALE) || (c == CMD_FREQ) || (c == CMD_INPUT_ON) || (c == CMD_INPUT_OFF)
         || (c == CMD_SYNC) || (c == CMD_OV_LIMIT) || (c == CMD_STATUS);
   endfunction

   // Unsigned word to millivolts using the output format exponent
   function automatic logic [31:0] ulin_to_mv(input logic [15:0] v, input logic [4:0] e);
      logic [31:0] p;
      p = 32'(v) * 32'd1000;
      if (e[4]) begin
         ulin_to_mv = p >> (5'(~e) + 5'h01);
      end else begin
         ulin_to_mv = p << e;
      end
   endfunction

   // Mode from the stored code; stored code is always one of four
   function automatic pmbcf_sync_e sync_mode(input logic [15:0] c);
      case (c)
         SYNC_STANDALONE: sync_mode = PMBCF_STANDALONE;
         SYNC_SLAVE_0: sync_mode = PMBCF_SLAVE_0;
         SYNC_SLAVE_180: sync_mode = PMBCF_SLAVE_180;
         default: sync_mode = PMBCF_MASTER;
      endcase
   endfunction

   // Pin level inputs cross into the clock domain through two flops
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         sync_ff <= 2'h0;
         sync_prev <= 1'b0;
         vdd_ff <= 2'h0;
         pin_ff <= 2'h0;
      end else if (ce_i) begin
         sync_ff <= {sync_ff[0], freq_resistor_sync_pin_i};
         sync_prev <= sync_ff[1];
         vdd_ff <= {vdd_ff[0], vdd_ok_i};
         pin_ff <= {pin_ff[0], setpoint_resistor_pin_i};
      end
   end

   assign ext_edge = sync_ff[1] && !sync_prev;
   assign mode = sync_mode(phase_sync_config);

   // Write validation per command
   always_comb begin
      wr_ok = 1'b0;
      case (cmd_code_i)
         CMD_SCALE: begin
            // fixed exponent is part of each accepted code
            // only the four scale codes pass
            wr_ok = (wr_data_i == SCALE_1_0) || (wr_data_i == SCALE_0_5)
               || (wr_data_i == SCALE_0_25) || (wr_data_i == SCALE_0_125);
         end
         CMD_FREQ: begin
            // exponent field sits above the mantissa
            wr_ok = (wr_data_i[L11_EXP_MSB:L11_EXP_LSB] == EXP_FREQ)
               && (wr_data_i[L11_MAN_MSB:0] >= FREQ_MIN_KHZ)
               && (wr_data_i[L11_MAN_MSB:0] <= FREQ_MAX_KHZ)
               && ((wr_data_i[L11_MAN_MSB:0] % FREQ_STEP_KHZ) == 11'h000);
         end
         CMD_INPUT_ON, CMD_INPUT_OFF: begin
            // half-volt steps from 1 V to 80 V
            wr_ok = (wr_data_i[L11_EXP_MSB:L11_EXP_LSB] == EXP_VIN)
               && (wr_data_i[L11_MAN_MSB:0] >= VIN_MAN_MIN)
               && (wr_data_i[L11_MAN_MSB:0] <= VIN_MAN_MAX);
         end
         CMD_SYNC: begin
            wr_ok = (wr_data_i == SYNC_STANDALONE) || (wr_data_i == SYNC_MASTER)
               || (wr_data_i == SYNC_SLAVE_0) || (wr_data_i == SYNC_SLAVE_180);
         end
         CMD_OV_LIMIT: begin
            wr_ok = (ulin_to_mv(wr_data_i, output_format_mode_i[OFM_EXP_MSB:0]) >= OV_MIN_MV)
               && (ulin_to_mv(wr_data_i, output_format_mode_i[OFM_EXP_MSB:0]) <= OV_MAX_MV);
         end
         CMD_STATUS: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   assign wr_bad = wr_en_i && !wr_ok;
   assign rd_bad = rd_en_i && !is_known(cmd_code_i);

   // scale choice from the setpoint voltage in millivolts
   always_comb begin
      if (setpoint_mv_i < AUTO_LIM_1_0_MV) begin
         auto_scale = SCALE_1_0;
      end else if (setpoint_mv_i < AUTO_LIM_0_5_MV) begin
         auto_scale = SCALE_0_5;
      end else if (setpoint_mv_i <= AUTO_LIM_0_25_MV) begin
         auto_scale = SCALE_0_25;
      end else begin
         auto_scale = SCALE_0_125;
      end
   end

   // Scale register; pin setpoint mode overrides host writes
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         output_scale_factor <= RST_SCALE;
      end else if (ce_i) begin
         if (pin_ff[1]) begin
            // automatic choice while pin sets output
            output_scale_factor <= auto_scale;
         end else if (wr_en_i && wr_ok && cmd_code_i == CMD_SCALE) begin
            // host keeps scale consistent with setpoint
            output_scale_factor <= wr_data_i;
         end
      end
   end

   // Numeric configuration registers
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         switching_freq_setting <= RST_FREQ;
         input_turn_on_threshold <= RST_INPUT_ON;
         input_turn_off_threshold <= RST_INPUT_OFF;
         output_overvoltage_limit <= RST_OV_LIMIT;
      end else if (ce_i && wr_en_i && wr_ok) begin
         case (cmd_code_i)
            CMD_FREQ: switching_freq_setting <= wr_data_i;
            CMD_INPUT_ON: input_turn_on_threshold <= wr_data_i;
            CMD_INPUT_OFF: input_turn_off_threshold <= wr_data_i;
            CMD_OV_LIMIT: output_overvoltage_limit <= wr_data_i;
            default: ;
         endcase
      end
   end

   // Sync mode register
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         phase_sync_config <= RST_SYNC;
      end else if (ce_i && wr_en_i && wr_ok && cmd_code_i == CMD_SYNC) begin
         phase_sync_config <= wr_data_i;
      end
   end

   // Frequency source flag; once a command lands the resistor is ignored
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         freq_cmd_seen <= 1'b0;
      end else if (ce_i && wr_en_i && wr_ok && cmd_code_i == CMD_FREQ) begin
         // command value takes over in every mode
         freq_cmd_seen <= 1'b1;
      end
   end

   assign freq_eff = freq_cmd_seen ? switching_freq_setting[L11_MAN_MSB:0] : rt_freq_khz_i;

   // Sticky error; a new error in the clearing cycle wins
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         cmd_err_o <= 1'b0;
      end else if (ce_i) begin
         // error latched until host clears it
         if (wr_bad || rd_bad) begin
            cmd_err_o <= 1'b1;
         end else if (wr_en_i && cmd_code_i == CMD_STATUS) begin
            cmd_err_o <= 1'b0;
         end
      end
   end

   // Thresholds in millivolts from the half-volt mantissa
   assign on_mv = 32'(input_turn_on_threshold[L11_MAN_MSB:0]) * VIN_MV_PER_LSB;
   assign off_mv = 32'(input_turn_off_threshold[L11_MAN_MSB:0]) * VIN_MV_PER_LSB;
   // output exponent from format mode field
   assign ov_mv = ulin_to_mv(output_overvoltage_limit, output_format_mode_i[OFM_EXP_MSB:0]);

   // Conversion enable with on/off hysteresis
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         conv_en_o <= 1'b0;
      end else if (ce_i) begin
         if (!conv_en_o && vin_mv_i >= on_mv) begin
            conv_en_o <= 1'b1;
         end else if (conv_en_o && vin_mv_i <= off_mv) begin
            conv_en_o <= 1'b0;
         end
      end
   end

   // Overvoltage detect; response handling lives elsewhere
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         ov_fault_o <= 1'b0;
      end else if (ce_i) begin
         ov_fault_o <= vout_mv_i > ov_mv;
      end
   end

   // slaves phase-lock to the sync pin edge
   pmbcf_phase_gen u_phase (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .freq_khz_i(freq_eff),
      .slave_i(mode == PMBCF_SLAVE_0 || mode == PMBCF_SLAVE_180),
      .anti_phase_i(mode == PMBCF_SLAVE_180),
      .ext_edge_i(ext_edge),
      .sw_clk_o(sw_clk_o)
   );

   // Sync pin drive only in master mode with supply good
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         freq_resistor_sync_pin_oe_o <= 1'b0;
      end else if (ce_i) begin
         // master output after internal supply good
         freq_resistor_sync_pin_oe_o <= (mode == PMBCF_MASTER) && vdd_ff[1];
      end
   end

   // Sync out follows the 50% switching clock
   assign freq_resistor_sync_pin_o = sw_clk_o;
   assign output_scale_factor_o = output_scale_factor;

   // Read port, one cycle after the request
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         rd_data_o <= 16'h0000;
         rd_valid_o <= 1'b0;
      end else if (ce_i) begin
         rd_valid_o <= rd_en_i;
         if (rd_en_i) begin
            case (cmd_code_i)
               CMD_SCALE: rd_data_o <= output_scale_factor;
               CMD_FREQ: rd_data_o <= switching_freq_setting;
               CMD_INPUT_ON: rd_data_o <= input_turn_on_threshold;
               CMD_INPUT_OFF: rd_data_o <= input_turn_off_threshold;
               CMD_SYNC: rd_data_o <= phase_sync_config;
               CMD_OV_LIMIT: rd_data_o <= output_overvoltage_limit;
               CMD_STATUS: rd_data_o <= 16'(
                  {freq_cmd_seen, ov_fault_o, conv_en_o, cmd_err_o} << ST_CMD_ERR);
               default: rd_data_o <= 16'h0000;
            endcase
         end
      end
   end

   // Helper sequences
   sequence s_bad_write;
      ce_i && wr_en_i && !wr_ok;
   endsequence

   a_reject_flags_err: assert property (@(posedge mclk_i) disable iff (srst_i)
      s_bad_write |=> cmd_err_o) else $error("Refused write did not set error");
   a_reject_keeps_freq: assert property (@(posedge mclk_i) disable iff (srst_i)
      (s_bad_write and cmd_code_i == CMD_FREQ) |=> $stable(switching_freq_setting))
      else $error("Refused frequency write changed register");
   a_reset_defaults: assert property (@(posedge mclk_i)
      srst_i |=> output_scale_factor == RST_SCALE && switching_freq_setting == RST_FREQ
      && input_turn_on_threshold == RST_INPUT_ON && input_turn_off_threshold == RST_INPUT_OFF
      && phase_sync_config == RST_SYNC && output_overvoltage_limit == RST_OV_LIMIT)
      else $error("Defaults not loaded by reset");
   a_scale_legal: assert property (@(posedge mclk_i) disable iff (srst_i)
      output_scale_factor[L11_EXP_MSB:L11_EXP_LSB] == EXP_SCALE)
      else $error("Scale register holds wrong exponent");
   a_conv_start: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && !conv_en_o && vin_mv_i >= on_mv |=> conv_en_o)
      else $error("Conversion did not start at threshold");
   a_conv_stop: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && conv_en_o && vin_mv_i <= off_mv |=> !conv_en_o)
      else $error("Conversion did not stop at threshold");
   a_ov_detect: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && vout_mv_i > ov_mv |=> ov_fault_o)
      else $error("Overvoltage not flagged");
   a_sync_drive: assert property (@(posedge mclk_i) disable iff (srst_i)
      freq_resistor_sync_pin_oe_o |-> $past(mode) == PMBCF_MASTER)
      else $error("Sync pin driven outside master mode");
   a_freq_override: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && wr_en_i && wr_ok && cmd_code_i == CMD_FREQ |=> freq_eff == $past(wr_data_i[L11_MAN_MSB:0]))
      else $error("Frequency command did not take over");
   a_auto_scale: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && pin_ff[1] |=> output_scale_factor == $past(auto_scale))
      else $error("Automatic scale not applied");
endmodule
`default_nettype wire

// File: verif/pmbcf_host_model.sv
// Purpose: Host model that issues configuration commands to the bank
// Assumes: One request per task call, strobes one cycle wide
// Notes:   Idle code lines carry the inverse of the last request, data lines that of the last write
`default_nettype none
module pmbcf_host_model
   import pmbcf_pkg::*;
(
   input wire logic mclk_i,
   output logic [7:0] cmd_code_o,
   output logic wr_en_o,
   output logic [15:0] wr_data_o,
   output logic rd_en_o,
   input wire logic rd_valid_i,
   input wire logic [15:0] rd_data_i
);
   timeunit 1ns;
   timeprecision 1ps;

   // Quiet bus at time zero
   initial begin
      cmd_code_o = 8'h00;
      wr_en_o = 1'b0;
      wr_data_o = 16'h0000;
      rd_en_o = 1'b0;
   end

   // Whole 16-bit word with its code, taken at one edge
   task automatic wr(input logic [7:0] code, input logic [15:0] data);
      @(posedge mclk_i);
      cmd_code_o <= code;
      wr_data_o <= data;
      wr_en_o <= 1'b1;
      @(posedge mclk_i);
      wr_en_o <= 1'b0;
      wr_data_o <= ~data;
      cmd_code_o <= ~code;
   endtask

   // Read answer is awaited a bounded time, unknown if it never comes
   task automatic rd(input logic [7:0] code, output logic [15:0] data);
      int n;
      @(posedge mclk_i);
      cmd_code_o <= code;
      rd_en_o <= 1'b1;
      @(posedge mclk_i);
      rd_en_o <= 1'b0;
      cmd_code_o <= ~code;
      n = 0;
      while (rd_valid_i !== 1'b1 && n < 4) begin
         @(posedge mclk_i);
         n++;
      end
      data = (rd_valid_i === 1'b1) ? rd_data_i : 16'hXXXX;
   endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// Purpose: Self-checking bench for the converter configuration bank
// Assumes: Host model owns the register port, bench drives the sensed side
// Notes:   Edge counts allow one edge of slack, the phase step is truncated
`default_nettype none
module tb
   import pmbcf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, spin = 1'b0, vdd_ok = 1'b0, ext_sync = 1'b0;
   logic [7:0] cmd_code, ofm = 8'h17;
   logic wr_en, rd_en, rd_valid, cmd_err, conv_en, ov_fault, sw_clk, sync_o, sync_oe, sync_wire;
   logic [15:0] wr_data, rd_data, scale, setpoint_mv = 16'h03E8;
   logic [10:0] rt_freq = 11'h3E8;
   logic [31:0] vin_mv = 32'h0, vout_mv = 32'h0;
   int failures = 0, samples_checked = 0, cycles = 0;

   // 250 MHz clock
   always #2 mclk_i = ~mclk_i;
   // Sync wire: device drives it only while enabled, else the external source
   assign sync_wire = sync_oe ? sync_o : ext_sync;

   pmbcf_host_model host (.mclk_i(mclk_i), .cmd_code_o(cmd_code), .wr_en_o(wr_en), .wr_data_o(wr_data),
      .rd_en_o(rd_en), .rd_valid_i(rd_valid), .rd_data_i(rd_data));

   pmbcf_bank DUT (.mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce_i), .cmd_code_i(cmd_code), .wr_en_i(wr_en),
      .wr_data_i(wr_data), .rd_en_i(rd_en), .output_format_mode_i(ofm), .setpoint_resistor_pin_i(spin),
      .setpoint_mv_i(setpoint_mv), .rt_freq_khz_i(rt_freq), .vin_mv_i(vin_mv), .vout_mv_i(vout_mv),
      .vdd_ok_i(vdd_ok), .freq_resistor_sync_pin_i(sync_wire), .freq_resistor_sync_pin_o(sync_o),
      .freq_resistor_sync_pin_oe_o(sync_oe), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .cmd_err_o(cmd_err),
      .conv_en_o(conv_en), .ov_fault_o(ov_fault), .sw_clk_o(sw_clk), .output_scale_factor_o(scale));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // Write, read back, check the error flag, then clear it
   task automatic wchk(input logic [7:0] code, input logic [15:0] data, input logic [15:0] rb, input logic err);
      logic [15:0] d;
      host.wr(code, data);
      host.rd(code, d);
      check(d, rb);
      check(16'(cmd_err), 16'(err));
      host.wr(CMD_STATUS, 16'h0000);
   endtask

   // Edges and high time of the sync wire over 5000 cycles
   task automatic measure(output int edges, output int highs);
      logic prev;
      edges = 0;
      highs = 0;
      prev = sync_wire;
      repeat (5000) begin
         @(posedge mclk_i);
         edges += (sync_wire === 1'b1 && prev === 1'b0) ? 1 : 0;
         highs += (sync_wire === 1'b1) ? 1 : 0;
         prev = sync_wire;
      end
   endtask

   task automatic t_defaults();
      logic [7:0] codes [6] = '{8'h29, 8'h33, 8'h35, 8'h36, 8'h37, 8'h40};
      logic [15:0] vals [6] = '{16'hE808, 16'h0258, 16'hF814, 16'hF812, 16'h0100, 16'h0161};
      logic [15:0] d;
      for (int i = 0; i < 6; i++) begin
         host.rd(codes[i], d);
         check(d, vals[i]);
      end
      check(16'(cmd_err), 16'h0000);
      $display("test defaults done");
   endtask

   task automatic t_master();
      int e, h;
      check(16'(sync_oe), 16'h0000);
      @(posedge mclk_i);
      vdd_ok <= 1'b1;
      repeat (6) @(posedge mclk_i);
      check(16'(sync_oe), 16'h0001);
      measure(e, h);
      check(16'(e >= 19 && e <= 21), 16'h0001);
      check(16'(h >= 2240 && h <= 2760), 16'h0001);
      wchk(CMD_FREQ, 16'h01F4, 16'h01F4, 1'b0);
      measure(e, h);
      check(16'(e >= 9 && e <= 11), 16'h0001);
      check(16'(h >= 2240 && h <= 2760), 16'h0001);
      $display("test master done");
   endtask

   task automatic t_slave();
      logic [15:0] modes [2] = '{16'h0120, 16'h0121};
      wchk(CMD_SYNC, 16'h0000, 16'h0000, 1'b0);
      wchk(CMD_SYNC, 16'h0101, 16'h0000, 1'b1);
      for (int i = 0; i < 2; i++) begin
         wchk(CMD_SYNC, modes[i], modes[i], 1'b0);
         check(16'(sync_oe), 16'h0000);
         @(posedge mclk_i);
         ext_sync <= 1'b1;
         repeat (2) @(posedge mclk_i);
         ext_sync <= 1'b0;
         repeat (6) @(posedge mclk_i);
         check(16'(sw_clk), 16'(i));
      end
      wchk(CMD_SYNC, 16'h0100, 16'h0100, 1'b0);
      $display("test slave done");
   endtask

   task automatic t_scale();
      logic [15:0] codes [4] = '{16'hE804, 16'hE802, 16'hE801, 16'hE808};
      logic [15:0] mv [4] = '{16'h09C4, 16'h1388, 16'h1770, 16'h03E8};
      for (int i = 0; i < 4; i++) wchk(CMD_SCALE, codes[i], codes[i], 1'b0);
      wchk(CMD_SCALE, 16'hE803, 16'hE808, 1'b1);
      wchk(CMD_SCALE, 16'hF008, 16'hE808, 1'b1);
      wchk(8'h50, 16'h1234, 16'h0000, 1'b1);
      @(posedge mclk_i);
      spin <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         setpoint_mv <= mv[i];
         repeat (6) @(posedge mclk_i);
         check(scale, (i == 3) ? 16'hE808 : codes[i]);
      end
      spin <= 1'b0;
      repeat (4) @(posedge mclk_i);
      wchk(CMD_SCALE, 16'hE808, 16'hE808, 1'b0);
      $display("test scale done");
   endtask

   task automatic t_limits();
      logic [15:0] d;
      wchk(CMD_FREQ, 16'h012C, 16'h012C, 1'b0);
      wchk(CMD_FREQ, 16'h05DC, 16'h05DC, 1'b0);
      wchk(CMD_FREQ, 16'h0113, 16'h05DC, 1'b1);
      wchk(CMD_FREQ, 16'h0145, 16'h05DC, 1'b1);
      wchk(CMD_FREQ, 16'h05F0, 16'h05DC, 1'b1);
      wchk(CMD_FREQ, 16'h092C, 16'h05DC, 1'b1);
      // Clock enable low freezes the bank, so this write is never taken
      ce_i <= 1'b0;
      host.wr(CMD_FREQ, 16'h0190);
      ce_i <= 1'b1;
      host.rd(CMD_FREQ, d);
      check(d, 16'h05DC);
      check(16'(cmd_err), 16'h0000);
      wchk(CMD_INPUT_ON, 16'hF802, 16'hF802, 1'b0);
      wchk(CMD_INPUT_ON, 16'hF8A0, 16'hF8A0, 1'b0);
      wchk(CMD_INPUT_ON, 16'hF801, 16'hF8A0, 1'b1);
      wchk(CMD_INPUT_ON, 16'hF8A1, 16'hF8A0, 1'b1);
      wchk(CMD_INPUT_ON, 16'h0814, 16'hF8A0, 1'b1);
      wchk(CMD_INPUT_OFF, 16'hF800, 16'hF812, 1'b1);
      wchk(CMD_INPUT_ON, 16'hF814, 16'hF814, 1'b0);
      $display("test limits done");
   endtask

   task automatic t_power();
      logic [31:0] vins [4] = '{32'd9999, 32'd10000, 32'd9001, 32'd9000};
      logic [31:0] vouts [4] = '{32'd680, 32'd700, 32'd990, 32'd1010};
      logic [15:0] d;
      for (int i = 0; i < 4; i++) begin
         vin_mv <= vins[i];
         repeat (4) @(posedge mclk_i);
         check(16'(conv_en), 16'(i == 1 || i == 2));
      end
      for (int i = 0; i < 4; i++) begin
         if (i == 2) wchk(CMD_OV_LIMIT, 16'h0200, 16'h0200, 1'b0);
         vout_mv <= vouts[i];
         repeat (4) @(posedge mclk_i);
         check(16'(ov_fault), 16'(i % 2));
      end
      wchk(CMD_OV_LIMIT, 16'h0010, 16'h0200, 1'b1);
      // Status word: error set by the refused sync write, frequency command seen, fault on, conversion off
      host.wr(CMD_SYNC, 16'h0007);
      host.rd(CMD_STATUS, d);
      check(d, 16'h000D);
      host.wr(CMD_STATUS, 16'h0000);
      host.rd(CMD_STATUS, d);
      check(d, 16'h000C);
      $display("test power done");
   endtask

   task automatic finish_test();
      $display("checks=%0d failures=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Hang guard, about four times the expected run
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         finish_test();
      end
   end

   // Main sequence; master run right after the defaults check, before any frequency write
   initial begin
      repeat (4) @(posedge mclk_i);
      srst_i <= 1'b0;
      t_defaults();
      t_master();
      t_slave();
      t_scale();
      t_limits();
      t_power();
      finish_test();
   end
endmodule
`default_nettype wire
